//--- rtl/mpm_pkg.sv
// Purpose: Shared constants and types of the multiphase DPWM phase manager
// Assumes: 32-bit AHB-Lite register bus, one 200 MHz clock
// Notes: Register byte offsets live here
package mpm_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SLOT_US = 200;
  localparam int SLOT_CYCLES = SLOT_US * CLK_MHZ;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_ALLOC = 8'h08;
  localparam logic [7:0] OFS_SYNC = 8'h0C;
  localparam logic [7:0] OFS_LLCFG = 8'h10;
  localparam logic [7:0] OFS_LLLIM = 8'h14;
  localparam logic [7:0] OFS_FLIM = 8'h18;
  localparam logic [7:0] OFS_TRIP = 8'h1C;
  localparam logic [7:0] OFS_CAL0 = 8'h20;
  localparam logic [7:0] OFS_IOUT = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [15:0] RST_PERIOD = 16'h00C8;
  localparam logic [15:0] RST_GAIN = 16'h1000;
  localparam logic [7:0] RST_SYNC_OUT = 8'hFF;
  localparam int CAL_SHIFT = 12;
  localparam int FILT_SHIFT = 2;
  localparam logic [16:0] SPREAD_3_13 = 17'h03B14;
  localparam logic [16:0] THIRD = 17'h05556;
  typedef enum logic [1:0] {
    AD_IDLE = 2'b00,
    AD_START = 2'b01,
    AD_WAIT = 2'b11
  } mpm_adc_state_t;
  typedef enum logic {
    LD_NORMAL = 1'b0,
    LD_SHED = 1'b1
  } mpm_load_state_t;
  typedef struct packed {
    logic mapped;
    logic rail;
    logic [1:0] idx;
  } mpm_stage_map_t;
  typedef struct packed {
    logic start;
    logic [1:0] chan;
  } mpm_adc_req_t;
endpackage

//--- rtl/mpm_dpwm_phase_manager.sv
// Purpose: Multi-rail multiphase DPWM engine with sync, shedding and current monitor
// Assumes: AHB-Lite slave, shared external 12-bit converter, inputs synchronous
// Notes: Four stages on at most two rails; compensator supplies duty words
//
// What this block does
// R1 - Threshold is duty times period, compared to counter
// R2 - Drive rises at shifted period start, falls at threshold
// R3 - One or two rails, up to four stages
// R4 - Host avoids 1:3 and empty first rail
// R5 - Host assigns stages in fixed order
// R6 - Second rail lags by 3/13 faster period
// R7 - Stages in a rail spread period over count
// R8 - Sync rising edge resets following rail counters
// R9 - Sync word upper byte picks sync output stage
// R10 - Sync word lower byte is rail follow mask
// R11 - Sync lock drops rail offset until soft reset
// R12 - Shed stages when averaged current below low limit
// R13 - Light-load coefficients selected on shedding entry
// R14 - Restore all stages above high limit
// R15 - Normal coefficients restored on leaving light load
// R16 - One rail per 200 us sampling slot
// R17 - First-order smoothing, about 3.5 samples
// R18 - Only averaged currents meet fault thresholds
// R19 - Averaged current outside limits declares fault
// R20 - Per-channel gain and offset calibration
// R21 - Readback returns rail sum of averages
// R22 - One shared converter steps through inputs
// R23 - Comparator disabled when trip level zero
// R24 - Light-load bank used below light-load limit
// R25 - Fast trip kills rail drives and rectifiers
// R26 - Hysteretic shed and restore per rail
`timescale 1ns/100ps
`default_nettype none
module mpm_dpwm_phase_manager
  import mpm_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES,
  parameter int PW = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Compensator
  input wire logic [1:0][15:0] compDuty,
  output logic [1:0] lightCoefSel,
  // Stage drives
  output logic first_stage_drive,
  output logic second_stage_drive,
  output logic third_stage_drive,
  output logic fourth_stage_drive,
  output logic [3:0] rectifier_enable_out,
  // Sync pins
  input wire logic syncIn,
  output logic syncOut,
  // Shared converter
  output mpm_pkg::mpm_adc_req_t adcReq,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  // Fast comparators on stages 1A, 2A, 3A
  output logic [2:0][5:0] comparator_trip_level,
  output logic [2:0] cmpEnable,
  input wire logic [2:0] cmpTrip
);
  import mpm_pkg::*;

  function automatic logic [PW-1:0] scale(input logic [PW-1:0] p, input logic [16:0] f);
    logic [PW+16:0] prod;
    prod = p * f;
    scale = prod[PW+15:16];
  endfunction

  // Offset of stage idx within a rail of n stages
  function automatic logic [PW-1:0] phaseOfs(input logic [PW-1:0] p, input logic [2:0] n,
                                              input logic [1:0] idx);
    logic [PW-1:0] step;
    step = '0;
    case (n)
      3'd2: step = p >> 1;
      3'd3: step = scale(p, THIRD);
      3'd4: step = p >> 2;
      default: step = '0;
    endcase
    phaseOfs = PW'(step * idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic ctrlShut;
  logic [1:0][PW-1:0] period;
  logic [2:0] nRail1;
  logic [1:0] nRail2;
  logic [15:0] syncCfg;
  logic [1:0] shedEn;
  logic coefEn;
  logic [1:0][1:0] shedCnt;
  logic [15:0] llLow, llHigh, ucLim, ocLim;
  logic [2:0][5:0] tripLvl;
  logic [3:0][15:0] calGain, calOfs;
  logic [1:0] ocFlt, ucFlt, fastFlt;
  logic syncLocked;
  logic [3:0][15:0] avgCur;
  logic [1:0][16:0] railSum;
  mpm_load_state_t [1:0] loadSt;

  logic dpValid, dpWrite;
  logic [7:0] dpAddr;
  logic wrEn;
  logic [31:0] wd;
  logic softReset;
  logic [1:0] next_ocFlt, next_ucFlt, next_fastFlt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr <= '0;
    end else if (hready) begin
      dpValid <= hsel & htrans[1];
      dpWrite <= hwrite;
      dpAddr <= haddr[7:0];
    end
  end

  assign wrEn = dpValid & dpWrite;
  assign wd = hwdata;
  assign softReset = wrEn && dpAddr == OFS_CTRL && wd[0];

  // Single-word accesses only: byte lanes are not decoded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlShut <= 1'b0;
      period <= {RST_PERIOD, RST_PERIOD};
      nRail1 <= 3'd1;
      nRail2 <= 2'd0;
      syncCfg <= {RST_SYNC_OUT, 8'h00};
      shedEn <= '0;
      coefEn <= 1'b0;
      shedCnt <= '0;
      llLow <= '0;
      llHigh <= '0;
      ucLim <= '0;
      ocLim <= 16'hFFFF;
      tripLvl <= '0;
      calGain <= {4{RST_GAIN}};
      calOfs <= '0;
    end else if (wrEn) begin
      if (dpAddr == OFS_CTRL) begin
        ctrlShut <= wd[1];
      end else if (dpAddr == OFS_PERIOD) begin
        period <= {wd[31:16], wd[15:0]};
      end else if (dpAddr == OFS_ALLOC) begin
        nRail1 <= wd[2:0];
        nRail2 <= wd[5:4];
      end else if (dpAddr == OFS_SYNC) begin
        syncCfg <= wd[15:0];
      end else if (dpAddr == OFS_LLCFG) begin
        shedEn <= wd[1:0];
        coefEn <= wd[2];
        shedCnt <= {wd[7:6], wd[5:4]};
      end else if (dpAddr == OFS_LLLIM) begin
        llLow <= wd[15:0];
        llHigh <= wd[31:16];
      end else if (dpAddr == OFS_FLIM) begin
        ucLim <= wd[15:0];
        ocLim <= wd[31:16];
      end else if (dpAddr == OFS_TRIP) begin
        tripLvl <= {wd[21:16], wd[13:8], wd[5:0]};
      end else if (dpAddr[7:4] == OFS_CAL0[7:4]) begin
        calGain[dpAddr[3:2]] <= wd[15:0];
        calOfs[dpAddr[3:2]] <= wd[31:16];
      end
    end
  end

  logic [7:0] ra;
  assign ra = haddr[7:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        if (ra == OFS_CTRL) begin
          hrdata <= {30'h0, ctrlShut, 1'b0};
        end else if (ra == OFS_PERIOD) begin
          hrdata <= {period[1], period[0]};
        end else if (ra == OFS_ALLOC) begin
          hrdata <= {26'h0, nRail2, 1'b0, nRail1};
        end else if (ra == OFS_SYNC) begin
          hrdata <= {16'h0, syncCfg};
        end else if (ra == OFS_LLCFG) begin
          hrdata <= {24'h0, shedCnt, 1'b0, coefEn, shedEn};
        end else if (ra == OFS_LLLIM) begin
          hrdata <= {llHigh, llLow};
        end else if (ra == OFS_FLIM) begin
          hrdata <= {ocLim, ucLim};
        end else if (ra == OFS_TRIP) begin
          hrdata <= {10'h0, tripLvl[2], 2'b0, tripLvl[1], 2'b0, tripLvl[0]};
        end else if (ra[7:4] == OFS_CAL0[7:4]) begin
          hrdata <= {calOfs[ra[3:2]], calGain[ra[3:2]]};
        end else if (ra == OFS_IOUT) begin
          // Saturate the 17-bit sums into the 16-bit readback fields
          hrdata <= {railSum[1][16] ? 16'hFFFF : railSum[1][15:0], // R21
                     railSum[0][16] ? 16'hFFFF : railSum[0][15:0]};
        end else if (ra == OFS_STATUS) begin
          hrdata <= {23'h0, syncLocked, loadSt[1], loadSt[0], fastFlt, ucFlt, ocFlt};
        end else begin
          hrdata <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage allocation
  mpm_stage_map_t [3:0] smap;
  logic [1:0][2:0] nStages;

  always_comb begin
    nStages[0] = nRail1;
    nStages[1] = {1'b0, nRail2};
    smap[0] = '{mapped: nRail1 != 3'd0, rail: 1'b0, idx: 2'd0}; // R3
    smap[1] = '{mapped: nRail1 >= 3'd2, rail: 1'b0, idx: 2'd1};
    if (nRail2 != 2'd0) begin
      smap[2] = '{mapped: 1'b1, rail: 1'b1, idx: 2'd0};
    end else begin
      smap[2] = '{mapped: nRail1 >= 3'd3, rail: 1'b0, idx: 2'd2};
    end
    if (nRail2 == 2'd2) begin
      smap[3] = '{mapped: 1'b1, rail: 1'b1, idx: 2'd1};
    end else if (nRail1 == 3'd4) begin
      smap[3] = '{mapped: 1'b1, rail: 1'b0, idx: 2'd3};
    end else begin
      // 3:1 puts the third first-rail stage on 3A
      smap[3] = '{mapped: nRail1 == 3'd3 && nRail2 == 2'd1, rail: 1'b0, idx: 2'd2}; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period counters and sync
  logic [1:0][PW-1:0] cnt;
  logic syncPrev;
  logic syncRise;
  logic [1:0] followSync;

  assign syncRise = syncIn & ~syncPrev;
  assign followSync = syncCfg[1:0]; // R10

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncPrev <= 1'b0;
    end else begin
      syncPrev <= syncIn;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      for (int r = 0; r < 2; r++) begin
        if (syncRise && followSync[r]) begin
          cnt[r] <= '0; // R8
        end else if (cnt[r] >= period[r] - PW'(1)) begin
          cnt[r] <= '0;
        end else begin
          cnt[r] <= cnt[r] + PW'(1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncLocked <= 1'b0;
    end else if (syncRise && (followSync != 2'b00)) begin
      syncLocked <= 1'b1; // R11
    end else if (softReset) begin
      syncLocked <= 1'b0; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse generation
  logic [PW-1:0] fastPeriod, railOfs;
  logic [1:0][PW-1:0] thresh;
  logic [1:0] railKill;
  logic [3:0] next_drive;
  logic [3:0] stageOn;

  always_comb begin
    fastPeriod = (period[1] < period[0]) ? period[1] : period[0];
    railOfs = (nRail2 != 2'd0 && !syncLocked) ? scale(fastPeriod, SPREAD_3_13) : '0; // R6
    for (int r = 0; r < 2; r++) begin
      thresh[r] = scale(period[r], {1'b0, compDuty[r]}); // R1
      railKill[r] = fastFlt[r] | (ctrlShut & (ocFlt[r] | ucFlt[r])); // R25
    end
    for (int s = 0; s < 4; s++) begin
      logic [PW+1:0] lc;
      logic [PW+1:0] p;
      logic r;
      r = smap[s].rail;
      p = {2'b0, period[r]};
      lc = {2'b0, cnt[r]} + (p << 1)
           - {2'b0, phaseOfs(period[r], nStages[r], smap[s].idx)} // R7
           - (r ? {2'b0, railOfs} : '0);
      if (lc >= p) begin
        lc = lc - p;
      end
      if (lc >= p) begin
        lc = lc - p;
      end
      stageOn[s] = smap[s].mapped && !railKill[r]
                   && !(loadSt[r] == LD_SHED
                        && {1'b0, smap[s].idx} >= nStages[r] - {1'b0, shedCnt[r]}); // R12
      next_drive[s] = stageOn[s] && (lc < {2'b0, thresh[r]}); // R2
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_stage_drive <= 1'b0;
      second_stage_drive <= 1'b0;
      third_stage_drive <= 1'b0;
      fourth_stage_drive <= 1'b0;
      rectifier_enable_out <= '0;
      syncOut <= 1'b0;
    end else begin
      first_stage_drive <= next_drive[0];
      second_stage_drive <= next_drive[1];
      third_stage_drive <= next_drive[2];
      fourth_stage_drive <= next_drive[3];
      rectifier_enable_out <= stageOn & ~next_drive; // R25
      syncOut <= (syncCfg[15:8] < 8'd4) ? next_drive[syncCfg[9:8]] : 1'b0; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast comparators; a zero level means the comparator is off
  logic [1:0] tripRail;

  always_comb begin
    tripRail = '0;
    if (cmpEnable[0] && cmpTrip[0] && smap[0].mapped) tripRail[smap[0].rail] = 1'b1;
    if (cmpEnable[1] && cmpTrip[1] && smap[2].mapped) tripRail[smap[2].rail] = 1'b1;
    if (cmpEnable[2] && cmpTrip[2] && smap[3].mapped) tripRail[smap[3].rail] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_trip_level <= '0;
      cmpEnable <= '0;
    end else begin
      comparator_trip_level <= tripLvl;
      for (int c = 0; c < 3; c++) begin
        cmpEnable[c] <= tripLvl[c] != 6'd0; // R23
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current sampling: one rail per slot, converter shared by all inputs
  logic [31:0] slotCnt;
  logic slotRail;
  logic [1:0] curStage;
  mpm_adc_state_t adSt;
  logic slotTick;
  logic slotDone;
  logic [16:0] calCur;
  logic [27:0] gained;
  logic [17:0] diff;

  assign slotTick = slotCnt == 32'(SLOT_LEN - 1);
  assign gained = adcData * calGain[curStage];
  assign calCur = 17'(gained[27:CAL_SHIFT]) + {{1{calOfs[curStage][15]}}, calOfs[curStage]};
  assign diff = {1'b0, (calCur[16] ? 17'h0 : calCur)} - {2'b0, avgCur[curStage]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slotCnt <= '0;
      slotRail <= 1'b0;
    end else if (slotTick) begin
      slotCnt <= '0;
      slotRail <= (nRail2 != 2'd0) ? ~slotRail : 1'b0; // R16
    end else begin
      slotCnt <= slotCnt + 32'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adSt <= AD_IDLE;
      curStage <= '0;
      adcReq <= '0;
      avgCur <= '0;
      slotDone <= 1'b0;
    end else begin
      adcReq.start <= 1'b0;
      slotDone <= 1'b0;
      case (adSt)
        AD_IDLE: begin
          if (slotTick) begin
            curStage <= '0;
            adSt <= AD_START;
          end
        end
        AD_START: begin
          if (smap[curStage].mapped && smap[curStage].rail == slotRail) begin
            adcReq.start <= 1'b1; // R22
            adcReq.chan <= curStage;
            adSt <= AD_WAIT;
          end else if (curStage == 2'd3) begin
            slotDone <= 1'b1;
            adSt <= AD_IDLE;
          end else begin
            curStage <= curStage + 2'd1;
          end
        end
        AD_WAIT: begin
          if (adcDone) begin
            // Gain of 1/4 per sample gives a lag close to 3.5 samples
            avgCur[curStage] <= 16'(avgCur[curStage] + 16'($signed(diff) >>> FILT_SHIFT)); // R17 R20
            if (curStage == 2'd3) begin
              slotDone <= 1'b1;
              adSt <= AD_IDLE;
            end else begin
              curStage <= curStage + 2'd1;
              adSt <= AD_START;
            end
          end
        end
        default: adSt <= AD_IDLE;
      endcase
    end
  end

  always_comb begin
    railSum = '0;
    for (int s = 0; s < 4; s++) begin
      if (smap[s].mapped) railSum[smap[s].rail] = railSum[smap[s].rail] + 17'(avgCur[s]); // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Faults and light-load state
  always_comb begin
    next_ocFlt = ocFlt;
    next_ucFlt = ucFlt;
    next_fastFlt = fastFlt;
    if (wrEn && dpAddr == OFS_STATUS) begin
      next_ocFlt = ocFlt & ~wd[1:0];
      next_ucFlt = ucFlt & ~wd[3:2];
      next_fastFlt = fastFlt & ~wd[5:4];
    end
    for (int r = 0; r < 2; r++) begin
      if (slotDone && slotRail == r && nStages[r] != 3'd0) begin
        if (railSum[r] > {1'b0, ocLim}) next_ocFlt[r] = 1'b1; // R18 R19
        if (railSum[r] < {1'b0, ucLim}) next_ucFlt[r] = 1'b1; // R19
      end
      if (tripRail[r]) next_fastFlt[r] = 1'b1; // R25
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ocFlt <= '0;
      ucFlt <= '0;
      fastFlt <= '0;
    end else begin
      ocFlt <= next_ocFlt;
      ucFlt <= next_ucFlt;
      fastFlt <= next_fastFlt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadSt <= {LD_NORMAL, LD_NORMAL};
      lightCoefSel <= '0;
    end else begin
      for (int r = 0; r < 2; r++) begin
        case (loadSt[r])
          LD_NORMAL: begin
            if (shedEn[r] && slotDone && slotRail == r && railSum[r] < {1'b0, llLow}) begin
              loadSt[r] <= LD_SHED; // R12 R26
            end
          end
          LD_SHED: begin
            if (!shedEn[r] || (slotDone && slotRail == r && railSum[r] > {1'b0, llHigh})) begin
              loadSt[r] <= LD_NORMAL; // R14 R26
            end
          end
          default: loadSt[r] <= LD_NORMAL;
        endcase
        lightCoefSel[r] <= coefEn && loadSt[r] == LD_SHED; // R13 R15 R24
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/mpm_adc_model.sv
// Purpose: Behavioural model of the shared 12-bit current converter
// Assumes: One conversion per start pulse, bench sets the sensed level
// Notes: Latency grows with channel so prompt and slow answers both occur
`timescale 1ns/100ps
`default_nettype none
module mpm_adc_model
  import mpm_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Converter handshake
  input wire mpm_pkg::mpm_adc_req_t adcReq,
  input wire logic [11:0] level,
  output logic adcDone,
  output logic [11:0] adcData
);
  int waitN = 0;
  initial begin
    adcDone = 1'b0;
    adcData = 12'h000;
  end
  ////////////////////////////////////////////////////////////////////////
  // Data bus toggles outside a result so stale values never look valid
  always @(posedge sys_clk) begin
    adcDone <= 1'b0;
    if (adcReq.start) begin
      waitN = 2 + 5 * int'(adcReq.chan);
    end else if (waitN > 1) begin
      waitN--;
    end
    if (waitN == 1) begin
      waitN = 0;
      adcDone <= 1'b1;
      adcData <= level;
    end else begin
      adcData <= ~adcData;
    end
  end
endmodule
`default_nettype wire

//--- bench/mpm_dpwm_phase_manager_chk.sv
// Purpose: Port-level checks of the phase manager
// Assumes: Single clock domain, reset asynchronous active low
// Notes: Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module mpm_chk
  import mpm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Stages
  input wire logic first_stage_drive,
  input wire logic second_stage_drive,
  input wire logic third_stage_drive,
  input wire logic fourth_stage_drive,
  input wire logic [3:0] rectifier_enable_out,
  input wire logic syncOut,
  // Converter and comparators
  input wire mpm_pkg::mpm_adc_req_t adcReq,
  input wire logic [2:0][5:0] comparator_trip_level,
  input wire logic [2:0] cmpEnable,
  input wire logic [2:0] cmpTrip
);
  logic [3:0] drv;
  assign drv = {fourth_stage_drive, third_stage_drive, second_stage_drive, first_stage_drive};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_ready; $past(rst_n) |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");
  property p_okay; hreadyout |-> !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_rdhold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  property p_rect; (rectifier_enable_out & drv) == 4'h0; endproperty
  a_rect: assert property (p_rect) else $error("rectifier on with drive");
  property p_trip;
    cmpTrip[0] && cmpEnable[0] |->
      ##[1:3] (drv[1:0] == 2'h0 && rectifier_enable_out[1:0] == 2'h0) [*8];
  endproperty
  a_trip: assert property (p_trip) else $error("rail not killed on trip");
  property p_cmpen;
    $stable(comparator_trip_level) |->
      cmpEnable == {|comparator_trip_level[2], |comparator_trip_level[1],
                    |comparator_trip_level[0]};
  endproperty
  a_cmpen: assert property (p_cmpen) else $error("comparator enable wrong");
  property p_syncout; syncOut |-> drv != 4'h0; endproperty
  a_syncout: assert property (p_syncout) else $error("sync out without drive");
  property p_adcpulse; adcReq.start |=> !adcReq.start [*2]; endproperty
  a_adcpulse: assert property (p_adcpulse) else $error("start too close");
  property p_adchold; !adcReq.start |-> $stable(adcReq.chan); endproperty
  a_adchold: assert property (p_adchold) else $error("channel moved");
  c_trip: cover property (cmpTrip[0] && cmpEnable[0]);
  c_adc: cover property (adcReq.start);
  c_sync: cover property (syncOut);
endmodule
bind mpm_dpwm_phase_manager mpm_chk i_mpm_chk (.sys_clk, .rst_n, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .first_stage_drive, .second_stage_drive,
  .third_stage_drive, .fourth_stage_drive, .rectifier_enable_out, .syncOut, .adcReq,
  .comparator_trip_level, .cmpEnable, .cmpTrip);
`default_nettype wire

//--- bench/test_multiphase_dpwm_phase_manager.sv
// Purpose: Self-checking bench of the phase manager
// Assumes: Zero-wait AHB-Lite slave, short current slot
// Notes: Converter model sits on the far side
`timescale 1ns/100ps
`default_nettype none
module test_multiphase_dpwm_phase_manager;
  import mpm_pkg::*;
  localparam int SLOT = 200;
  logic sys_clk, rst_n, hsel, hwrite, syncIn;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cmpTrip;
  logic [1:0][15:0] compDuty;
  logic [11:0] level;
  wire logic hreadyout, hresp, syncOut, adcDone;
  wire logic [31:0] hrdata;
  wire logic [1:0] lightCoefSel;
  wire logic [3:0] drv, rectifier_enable_out;
  wire mpm_adc_req_t adcReq;
  wire logic [11:0] adcData;
  wire logic [2:0][5:0] comparator_trip_level;
  wire logic [2:0] cmpEnable;
  int n_fail = 0;
  int n_compared = 0;
  mpm_dpwm_phase_manager #(.SLOT_LEN(SLOT)) i_mpm_dpwm_phase_manager (.sys_clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .compDuty, .lightCoefSel, .first_stage_drive(drv[0]), .second_stage_drive(drv[1]),
    .third_stage_drive(drv[2]), .fourth_stage_drive(drv[3]), .rectifier_enable_out, .syncIn,
    .syncOut, .adcReq, .adcDone, .adcData, .comparator_trip_level, .cmpEnable, .cmpTrip);
  mpm_adc_model i_mpm_adc_model (.sys_clk, .adcReq, .level, .adcDone, .adcData);
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single word transfer; waits on ready, no cycle count assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h000000, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic until_drv(input int s, input logic v, output int n);
    n = 0;
    while (drv[s] !== v && n < 1000) begin
      cyc(1); n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(0, OFS_PERIOD, 0); chk(rd, 32'h00C800C8);
    bus(0, OFS_ALLOC, 0); chk(rd, 32'h00000001);
    bus(0, OFS_SYNC, 0); chk(rd, 32'h0000FF00);
    bus(0, OFS_CAL0, 0); chk(rd, 32'h00001000);
    bus(0, 8'h40, 0); chk(rd, 32'h00000000);
  endtask
  task automatic t_pwm;
    int n, m;
    bus(1, OFS_PERIOD, 32'h00640064);
    bus(1, OFS_ALLOC, 32'h00000002);
    until_drv(0, 0, n); until_drv(0, 1, n); until_drv(0, 0, n);
    until_drv(1, 1, m);
    chk(32'(n), 32'd50);
    chk(32'(n + m), 32'd50);
    bus(1, OFS_ALLOC, 32'h00000011);
    until_drv(0, 0, n); until_drv(0, 1, n); until_drv(2, 1, m);
    chk(32'(m), 32'd23);
  endtask
  task automatic t_sync;
    int n, m;
    bus(1, OFS_SYNC, 32'h00000001);
    until_drv(0, 1, n); until_drv(0, 0, n);
    cyc(10);
    @(posedge sys_clk); syncIn <= 1'b1;
    until_drv(0, 1, n);
    chk(32'(n <= 5), 32'h1);
    syncIn <= 1'b0;
    m = 0;
    repeat (200) begin cyc(1); m += int'(syncOut !== drv[0]); end
    chk(32'(m), 32'h0);
    bus(0, OFS_STATUS, 0); chk(32'(rd[8]), 32'h1);
    bus(1, OFS_SYNC, 32'h00000400);
    m = 0;
    repeat (200) begin cyc(1); m += int'(syncOut !== 1'b0); end
    chk(32'(m), 32'h0);
    bus(1, OFS_CTRL, 32'h00000001);
    bus(0, OFS_STATUS, 0); chk(32'(rd[8]), 32'h0);
  endtask
  task automatic t_trip;
    int n, m;
    bus(1, OFS_TRIP, 32'h00000000);
    @(posedge sys_clk); cmpTrip <= 3'h1;
    until_drv(0, 1, n); until_drv(0, 0, n); until_drv(0, 1, n);
    chk(32'(n < 1000), 32'h1);
    cmpTrip <= 3'h0;
    bus(1, OFS_TRIP, 32'h0000003F);
    cyc(2);
    chk({26'h0, comparator_trip_level[0]}, 32'h3F);
    chk({31'h0, cmpEnable[0]}, 32'h1);
    @(posedge sys_clk); cmpTrip <= 3'h1;
    @(posedge sys_clk); cmpTrip <= 3'h0;
    cyc(3);
    m = 0;
    repeat (400) begin cyc(1); m += int'(drv[1:0] != 2'h0); end
    chk(32'(m), 32'h0);
    bus(0, OFS_STATUS, 0); chk(32'(rd[4]), 32'h1);
    bus(1, OFS_STATUS, 32'h00000030);
    until_drv(0, 1, n); chk(32'(n < 1000), 32'h1);
  endtask
  task automatic t_shed;
    int n;
    bus(1, OFS_ALLOC, 32'h00000002);
    bus(1, OFS_LLLIM, 32'h08000100);
    bus(1, OFS_FLIM, 32'h10000000);
    bus(1, OFS_LLCFG, 32'h00000015);
    level <= 12'h010;
    cyc(40 * SLOT);
    bus(0, OFS_STATUS, 0); chk(32'(rd[6]), 32'h1);
    chk({31'h0, lightCoefSel[0]}, 32'h1);
    until_drv(1, 1, n); chk(32'(n), 32'd1000);
    level <= 12'h200;
    cyc(40 * SLOT);
    bus(0, OFS_STATUS, 0); chk(32'(rd[6]), 32'h1);
    level <= 12'hFFF;
    cyc(40 * SLOT);
    bus(0, OFS_STATUS, 0); chk(32'(rd[6]), 32'h0);
    chk(32'(rd[0]), 32'h1);
    chk({31'h0, lightCoefSel[0]}, 32'h0);
    until_drv(1, 1, n); chk(32'(n < 1000), 32'h1);
    bus(0, OFS_IOUT, 0); chk(32'(rd[15:0] > 16'h1000), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #300000;
    n_fail++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; syncIn = 1'b0; haddr = 32'h0;
    hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2; cmpTrip = 3'h0; level = 12'h000;
    compDuty = {16'h8000, 16'h8000};
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(3);
    t_regs();
    t_pwm();
    t_sync();
    t_trip();
    t_shed();
    give_verdict();
  end
endmodule
`default_nettype wire
